// File: design/channel_config_and_id_regs.sv
// Purpose: identification word, channel registers, setups and channel sequencer
// Assumes: AHB-Lite slave, zero wait states, word accesses only
// Notes:   conversion engine sits outside and pulses conv_done per result;
//          reserved channel bits are dropped on write, so reads return zero;
//          the engine configuration follows the registers live, one edge late;
//          unmapped, misaligned and non-word accesses are ignored without error
//
// Implementation choice: register access over AHB-Lite.

`timescale 1ns/1ps

module channel_config_and_id_regs
    import chan_cfg_pkg::*;
#(
    // arbitrary neutral identification value
    parameter logic [15:0] ID_CODE = 16'h5A3C
)
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_b,
    // register bus
    input  wire ahb_req_t  ahb_req,
    output ahb_rsp_t       ahb_rsp,
    // conversion engine
    input  wire logic      conv_done,
    output logic           conv_start,
    output logic           seq_busy,
    output conv_cfg_t      conv_cfg
);

    // state of the block, apart from the reset synchroniser
    typedef struct packed
    {
        logic [3:0][15:0] chan;     // channel registers
        logic [3:0][15:0] setup;    // setup configuration words
        logic [3:0][15:0] filt;     // filter configuration words
        logic [3:0][15:0] offs;     // offset words
        logic [3:0][15:0] gain;     // gain words
        logic             wr_pend;  // write data phase due
        logic [5:0]       wr_idx;   // index of pending write
        logic [31:0]      rdata;    // read data for data phase
        seq_state_t       seq;      // sequencer state
        logic [1:0]       cur;      // channel being converted
        logic             start;    // new conversion pulse
        conv_cfg_t        cfg;      // live config to engine
    } regs_t;

    // state after reset
    localparam regs_t RST_S = '{
        // channel zero starts enabled, the other three disabled
        chan:    {CHAN_RST, CHAN_RST, CHAN_RST, CHAN0_RST},
        setup:   {NUM_PROF{SETUP_RST}},
        filt:    {NUM_PROF{FILT_RST}},
        offs:    {NUM_PROF{OFFS_RST}},
        gain:    {NUM_PROF{GAIN_RST}},
        // bus and sequencer start quiet
        wr_pend: 1'b0,
        wr_idx:  6'h00,
        rdata:   32'h00000000,
        seq:     SEQ_IDLE,
        cur:     2'h0,
        start:   1'b0,
        cfg:     '0
    };

    // reset and state
    logic [1:0]  rst_sync;  // reset release stages
    logic        rst_n;     // released reset for the block
    regs_t       s;         // current state
    regs_t       next_s;    // next state
    // bus decode
    logic        take;      // address phase accepted
    logic [5:0]  idx;       // decoded register index
    // sequencer helpers
    logic [3:0]  en;        // channel enable bits
    logic [1:0]  prof;      // setup picked by current channel

    // true when idx falls in the four-word block at base
    function automatic logic in_block(input logic [5:0] i, input logic [5:0] base);
        // low two index bits pick the word inside the block
        return i[5:2] == base[5:2];
    endfunction : in_block

    // next enabled channel after cur, wrapping, cur itself last
    // limitation: plain round robin, no per-channel priority
    function automatic logic [1:0] next_enabled(input logic [3:0] e, input logic [1:0] c);
        logic [1:0] pick;
        logic [1:0] cand;
        // with nothing enabled the current channel stays picked
        pick = c;
        cand = c;
        // walk from farthest to nearest so the nearest wins
        for (int k = 4; k >= 1; k--)
        begin
            cand = 2'(c + 2'(k));
            if (e[cand])
            begin
                // a nearer enabled channel overrides a farther one
                pick = cand;
            end
        end
        return pick;
    endfunction : next_enabled

    // read value of one register, unmapped words read zero
    // the status word is a debug view of the sequencer
    function automatic logic [31:0] read_word(input regs_t r, input logic [5:0] i,
                                              input logic [3:0] e);
        logic [31:0] w;
        // upper half and unmapped slots read zero
        w = 32'h00000000;
        if (i == IDX_ID)
        begin
            // fixed code, no storage behind it
            w[15:0] = ID_CODE;
        end
        else if (i == IDX_SEQ_STAT)
        begin
            // current channel, busy flag and enables side by side
            w[STAT_CUR_LSB +: 2] = r.cur;
            w[STAT_BUSY_BIT]     = (r.seq == SEQ_RUN);
            w[STAT_EN_LSB +: 4]  = e;
        end
        else if (in_block(i, IDX_CHAN_BASE))
        begin
            // stored already masked, reserved bits come back zero
            w[15:0] = r.chan[i[1:0]] & CH_WR_MASK;
        end
        else if (in_block(i, IDX_SETUP_BASE))
        begin
            // setup words are stored whole, no reserved bits
            w[15:0] = r.setup[i[1:0]];
        end
        else if (in_block(i, IDX_FILT_BASE))
        begin
            // filter word of the addressed setup
            w[15:0] = r.filt[i[1:0]];
        end
        else if (in_block(i, IDX_OFFS_BASE))
        begin
            // offset word of the addressed setup
            w[15:0] = r.offs[i[1:0]];
        end
        else if (in_block(i, IDX_GAIN_BASE))
        begin
            // gain word of the addressed setup
            w[15:0] = r.gain[i[1:0]];
        end
        return w;
    endfunction : read_word

    // reset release; first stage feeds only the second
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // assert at once, no clock needed
            rst_sync <= RST_SYNC_RST;
        end
        else
        begin
            // shift ones in; release lands on the second edge, which keeps
            // reset removal clear of a metastable first stage
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // only the second stage leaves the synchroniser
    assign rst_n = rst_sync[1];

    // channel enables gathered from each channel register
    generate
        for (genvar g = 0; g < NUM_CHAN; g++)
        begin : g_en
            // read by the sequencer and by the status word
            assign en[g] = s.chan[g][CH_EN_BIT];
        end
    endgenerate

    // address phase qualifier: selected, ready, active, whole word
    // hready is part of it so a stalled bus never takes a request twice;
    // byte and halfword accesses are dropped rather than half written
    assign take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]
                  && (ahb_req.hsize == HSIZE_WORD);

    // misaligned or out-of-range addresses map to an empty slot
    // upper address bits are decoded in full so no alias reaches a register;
    // the empty slot reads zero and swallows writes
    assign idx = (ahb_req.haddr[31:8] == 24'h000000 && ahb_req.haddr[1:0] == 2'h0)
                 ? ahb_req.haddr[7:2] : IDX_NONE;

    // next state: bus writes, read capture, sequencer, engine config
    always_comb
    begin
        // hold everything by default
        next_s       = s;
        // start is a one-cycle pulse
        next_s.start = 1'b0;
        // given a value on every path
        prof         = 2'h0;

        // data phase of an earlier write lands now
        if (s.wr_pend)
        begin
            if (in_block(s.wr_idx, IDX_CHAN_BASE))
            begin
                // reserved bits dropped at the door
                next_s.chan[s.wr_idx[1:0]] = ahb_req.hwdata[15:0] & CH_WR_MASK;
            end
            else if (in_block(s.wr_idx, IDX_SETUP_BASE))
            begin
                // upper data half is ignored
                next_s.setup[s.wr_idx[1:0]] = ahb_req.hwdata[15:0];
            end
            else if (in_block(s.wr_idx, IDX_FILT_BASE))
            begin
                // filter word, whole
                next_s.filt[s.wr_idx[1:0]] = ahb_req.hwdata[15:0];
            end
            else if (in_block(s.wr_idx, IDX_OFFS_BASE))
            begin
                // offset word, whole
                next_s.offs[s.wr_idx[1:0]] = ahb_req.hwdata[15:0];
            end
            else if (in_block(s.wr_idx, IDX_GAIN_BASE))
            begin
                // gain word, whole
                next_s.gain[s.wr_idx[1:0]] = ahb_req.hwdata[15:0];
            end
            // id, status and empty slots ignore writes
        end
        // a pending write lasts one data phase only
        next_s.wr_pend = 1'b0;

        // accept a new address phase
        if (take)
        begin
            if (ahb_req.hwrite)
            begin
                // data follows next cycle, so only the index is kept
                next_s.wr_pend = 1'b1;
                next_s.wr_idx  = idx;
            end
            else
            begin
                // read from next_s so a write just before is seen
                next_s.rdata = read_word(next_s, idx, en);
            end
        end

        // channel sequencer
        // the engine is only told to start; it reports back by conv_done
        unique case (s.seq)
            SEQ_IDLE:
            begin
                // first enabled channel, searching from channel 0
                if (|en)
                begin
                    next_s.seq   = SEQ_RUN;
                    next_s.cur   = next_enabled(en, 2'h3);
                    next_s.start = 1'b1;
                end
                else
                begin
                    // nothing enabled: stay idle
                    next_s.seq = SEQ_IDLE;
                end
            end
            SEQ_RUN:
            begin
                // stop first, so an emptied bank never starts again
                if (!(|en))
                begin
                    // all channels switched off, engine stops
                    next_s.seq = SEQ_IDLE;
                end
                // a result finished, or software switched the running channel
                // off; enables are registered, so a fresh one counts an edge late
                else if (conv_done || !en[s.cur])
                begin
                    // move on; a lone channel simply repeats
                    next_s.cur   = next_enabled(en, s.cur);
                    next_s.start = 1'b1;
                end
            end
        endcase

        // live config of the chosen channel; changes apply at once,
        // which is simpler than latching per conversion but lets
        // software disturb a conversion in flight
        prof                  = s.chan[next_s.cur][PROF_LSB +: 2];
        // the chosen channel travels with its settings
        next_s.cfg.channel    = next_s.cur;
        next_s.cfg.profile    = prof;
        // input selects pass through with no remapping
        next_s.cfg.pos_sel    = s.chan[next_s.cur][POS_LSB +: 5];
        next_s.cfg.neg_sel    = s.chan[next_s.cur][NEG_LSB +: 5];
        // all four words of the picked setup travel together
        next_s.cfg.setup_cfg  = s.setup[prof];
        next_s.cfg.filter_cfg = s.filt[prof];
        next_s.cfg.offset     = s.offs[prof];
        next_s.cfg.gain       = s.gain[prof];
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // whole bank back to its reset image
            s <= RST_S;
        end
        else
        begin
            // one register stage for every field
            s <= next_s;
        end
    end

    // bus answer: never waits, always okay
    // zero wait states, so every data phase completes in one cycle
    assign ahb_rsp.hreadyout = 1'b1;
    assign ahb_rsp.hresp     = 1'b0;
    assign ahb_rsp.hrdata    = s.rdata;

    // engine side, all from flip-flops
    // conv_cfg lags the registers by one edge; the engine latches it at conv_start
    assign conv_start = s.start;
    assign seq_busy   = (s.seq == SEQ_RUN);
    assign conv_cfg   = s.cfg;

endmodule : channel_config_and_id_regs

// File: common/chan_cfg_pkg.sv
// Purpose: shared constants and carrier types for the channel config bank
// Assumes: AHB-Lite word access, register index times four is the byte address
// Notes:   one place for every offset, field position and reset value

package chan_cfg_pkg;

    // bank geometry
    localparam int         NUM_CHAN       = 4;
    localparam int         NUM_PROF       = 4;

    // register indices (byte address = index * 4)
    localparam logic [5:0] IDX_SEQ_STAT   = 6'h01;
    localparam logic [5:0] IDX_ID         = 6'h07;
    localparam logic [5:0] IDX_CHAN_BASE  = 6'h10;
    localparam logic [5:0] IDX_SETUP_BASE = 6'h20;
    localparam logic [5:0] IDX_FILT_BASE  = 6'h28;
    localparam logic [5:0] IDX_OFFS_BASE  = 6'h30;
    localparam logic [5:0] IDX_GAIN_BASE  = 6'h38;
    localparam logic [5:0] IDX_NONE       = 6'h3F;

    // channel register field positions
    localparam int         CH_EN_BIT      = 15;
    localparam int         PROF_LSB       = 12;
    localparam int         POS_LSB        = 5;
    localparam int         NEG_LSB        = 0;
    localparam logic [15:0] CH_WR_MASK    = 16'hB3FF;

    // sequencer status field positions
    localparam int         STAT_CUR_LSB   = 0;
    localparam int         STAT_BUSY_BIT  = 2;
    localparam int         STAT_EN_LSB    = 4;

    // values after reset
    localparam logic [15:0] CHAN0_RST     = 16'h8001;
    localparam logic [15:0] CHAN_RST      = 16'h0001;
    localparam logic [15:0] SETUP_RST     = 16'h1320;
    localparam logic [15:0] FILT_RST      = 16'h0000;
    localparam logic [15:0] OFFS_RST      = 16'h0000;
    localparam logic [15:0] GAIN_RST      = 16'h0000;
    localparam logic [1:0]  RST_SYNC_RST  = 2'h0;

    // bus encodings
    localparam logic [2:0] HSIZE_WORD     = 3'h2;

    // sequencer states, one-hot
    typedef enum logic [1:0]
    {
        SEQ_IDLE = 2'h1,
        SEQ_RUN  = 2'h2
    } seq_state_t;

    // bus request from the master
    typedef struct packed
    {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } ahb_req_t;

    // bus answer to the master
    typedef struct packed
    {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } ahb_rsp_t;

    // configuration handed to the conversion engine
    typedef struct packed
    {
        logic [1:0]  channel;
        logic [1:0]  profile;
        logic [4:0]  pos_sel;
        logic [4:0]  neg_sel;
        logic [15:0] setup_cfg;
        logic [15:0] filter_cfg;
        logic [15:0] offset;
        logic [15:0] gain;
    } conv_cfg_t;

endpackage : chan_cfg_pkg

// File: tb/chan_cfg_asserts.sv
// Purpose: concurrent checks on the channel config bank ports
// Assumes: one clock, active-low reset, zero-wait bus slave
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module chan_cfg_asserts
    import chan_cfg_pkg::*;
#(
    parameter logic [15:0] ID_CODE = 16'h5A3C // arbitrary neutral value
)
(
    // clock and reset
    input wire logic      clk,
    input wire logic      rst_b,
    // register bus
    input wire ahb_req_t  ahb_req,
    input wire ahb_rsp_t  ahb_rsp,
    // conversion engine
    input wire logic      conv_done,
    input wire logic      conv_start,
    input wire logic      seq_busy,
    input wire conv_cfg_t conv_cfg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // word read taken at an address inside lo..hi
    sequence rd_in(lo, hi);
        ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite
            && ahb_req.hsize == HSIZE_WORD && ahb_req.haddr >= lo && ahb_req.haddr <= hi;
    endsequence
    // the slave never stalls and never errors
    bus_ready_a: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
        else $error("bus answer not ready or not okay");
    id_read_a: assert property (rd_in(32'h1C, 32'h1C) |=>
        ahb_rsp.hrdata == {16'h0000, ID_CODE})
        else $error("id word read wrong");
    rsv_zero_a: assert property (rd_in(32'h40, 32'h4C) |=>
        ahb_rsp.hrdata[14] == 1'b0 && ahb_rsp.hrdata[11:10] == 2'h0)
        else $error("reserved channel bits not zero");
    upper_zero_a: assert property (ahb_rsp.hrdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    start_busy_a: assert property (conv_start |-> seq_busy)
        else $error("start while sequencer idle");
    done_next_a: assert property (conv_done && seq_busy |=> conv_start)
        else $error("no start after a finished result");
    rise_start_a: assert property ($rose(seq_busy) |-> conv_start)
        else $error("sequencer woke without a start");
    fell_quiet_a: assert property ($fell(seq_busy) |-> !conv_start)
        else $error("start as sequencer went idle");
endmodule : chan_cfg_asserts

// File: tb/ahb_host_model.sv
// Purpose: host side bus master for the channel config bank
// Assumes: single word transfers, slave is the only one on the bus
// Notes:   tasks are called right after a rising edge
`timescale 1ns/1ps
module ahb_host_model
    import chan_cfg_pkg::*;
(
    // clock
    input wire logic clk,
    // bus
    output ahb_req_t req,
    input wire ahb_rsp_t rsp
);
    ahb_req_t r; // registered master signals
    initial r = '0;
    // hready is the slave's own readyout
    always_comb
    begin
        req        = r;
        req.hready = rsp.hreadyout;
    end
    // one transfer; callers keep reserved bits zero unless probing them
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        r.hsel   <= 1'b1;
        r.htrans <= 2'h2;
        r.hwrite <= w;
        r.haddr  <= a;
        r.hsize  <= HSIZE_WORD;
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        r.hsel   <= 1'b0;
        r.htrans <= 2'h0;
        r.hwdata <= d;
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        q = rsp.hrdata;
    endtask : xfer
endmodule : ahb_host_model

// File: tb/channel_config_and_id_regs_tb.sv
// Purpose: self-checking bench for the channel config bank
// Assumes: engine stand-in answers each start one cycle later
// Notes:   reserved bits are written as ones on purpose in one test
`timescale 1ns/1ps
module channel_config_and_id_regs_tb
    import chan_cfg_pkg::*;
;
    localparam logic [15:0] ID_CODE = 16'h5A3C; // arbitrary neutral value
    logic        clk       = 1'b0; // bench clock
    logic        rst_b     = 1'b0; // reset, active low
    logic        conv_done = 1'b0; // engine result pulse
    logic        eng_on    = 1'b1; // engine stand-in running
    logic        conv_start;
    logic        seq_busy;
    ahb_req_t    ahb_req;
    ahb_rsp_t    ahb_rsp;
    conv_cfg_t   conv_cfg;
    logic [31:0] q;
    logic [1:0]  c0;
    int          bad_count = 0;
    int          checks    = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    // engine stand-in: finishes one cycle after each start
    always @(posedge clk) conv_done <= conv_start && eng_on;
    channel_config_and_id_regs #(.ID_CODE(ID_CODE)) u_channel_config_and_id_regs
        (.clk(clk), .rst_b(rst_b), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
         .conv_done(conv_done), .conv_start(conv_start), .seq_busy(seq_busy),
         .conv_cfg(conv_cfg));
    ahb_host_model u_ahb_host_model (.clk(clk), .req(ahb_req), .rsp(ahb_rsp));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task rd(input logic [31:0] a, input logic [31:0] exp);
        u_ahb_host_model.xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd
    task wr(input logic [31:0] a, input logic [31:0] d);
        u_ahb_host_model.xfer(1'b1, a, d, q);
    endtask : wr
    // bounded wait for the next start; pulse and config are read at the edge
    // that ends the pulse, so both have stood a whole cycle; a miss is counted
    task wstart;
        repeat (40)
        begin
            @(posedge clk);
            if (conv_start === 1'b1) break;
        end
        chk(conv_start, 1'b1);
    endtask : wstart
    task t_reset;
        rd(32'h1C, {16'h0000, ID_CODE});
        rd(32'h40, 32'h8001);
        for (int i = 1; i < 4; i++) rd(32'h40 + 4 * i, 32'h0001);
        chk(seq_busy, 1'b1);
        chk(conv_cfg.neg_sel, 5'h01);
        chk(conv_cfg.setup_cfg, SETUP_RST);
        rd(32'h04, 32'h00000014);
    endtask : t_reset
    task t_id_ro;
        wr(32'h1C, 32'h0000FFFF);
        rd(32'h1C, {16'h0000, ID_CODE});
    endtask : t_id_ro
    // every setup code and input codes 0 to 3, reserved bits written as ones
    task t_fields;
        logic [1:0]  p;
        logic [31:0] e;
        for (int i = 0; i < 4; i++)
        begin
            p = i[1:0];
            e = {16'h0000, 1'b1, 1'b0, p, 2'h0, 3'h0, p, 3'h0, p ^ 2'h1};
            wr(32'h80 + 4 * i, {16'h0000, 14'h0440, p});
            wr(32'hA0 + 4 * i, {16'h0000, 14'h0660, p});
            wr(32'hC0 + 4 * i, {16'h0000, 14'h0770, p});
            wr(32'hE0 + 4 * i, {16'h0000, 14'h0880, p});
            wr(32'h40, e | 32'h4C00);
            rd(32'h40, e);
            wstart();
            chk(conv_cfg.profile, p);
            chk(conv_cfg.pos_sel, {3'h0, p});
            chk(conv_cfg.setup_cfg, {14'h0440, p});
            chk(conv_cfg.gain, {14'h0880, p});
            chk(conv_cfg.filter_cfg, {14'h0660, p});
            chk(conv_cfg.offset, {14'h0770, p});
            chk(conv_cfg.neg_sel, {3'h0, p ^ 2'h1});
        end
    endtask : t_fields
    // two channels sharing setup 0 alternate, then all off goes idle
    task t_seq;
        wr(32'h40, 32'h8001);
        wr(32'h48, 32'h8001);
        wstart();
        wstart();
        c0 = conv_cfg.channel;
        chk(c0 & 2'h1, 2'h0);
        chk(conv_cfg.profile, 2'h0);
        wstart();
        chk(conv_cfg.channel, c0 ^ 2'h2);
        wstart();
        chk(conv_cfg.channel, c0);
        eng_on <= 1'b0;
        wr(32'h40, 32'h0001);
        wr(32'h48, 32'h0001);
        repeat (4) @(posedge clk);
        #1;
        chk(seq_busy, 1'b0);
    endtask : t_seq
    task conclude;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_id_ro();
        t_fields();
        t_seq();
        conclude();
    end
    // watchdog, far beyond the hundred or so cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule : channel_config_and_id_regs_tb
bind channel_config_and_id_regs chan_cfg_asserts #(.ID_CODE(ID_CODE)) u_chan_cfg_asserts
    (.clk(clk), .rst_b(rst_b), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .conv_done(conv_done),
     .conv_start(conv_start), .seq_busy(seq_busy), .conv_cfg(conv_cfg));
